// ---- hdl/ssq_regs.svh ----
// Offsets, field positions, reset values and timing counts of the sequencer
`ifndef SSQ_REGS_SVH
`define SSQ_REGS_SVH

`define SSQ_REG_DELAY_MONITOR    3'h5
`define SSQ_REG_MONITOR_TIME     3'h6
`define SSQ_REG_ADVANCE_FLAGS    3'h7

`define SSQ_TIMEOUT_LSB          31
`define SSQ_TIMEOUT_MSB          34
`define SSQ_SELECT_LSB           35
`define SSQ_SELECT_MSB           38
`define SSQ_POLARITY_BIT         39
`define SSQ_ADV_WAIT_LSB         40
`define SSQ_ADV_WAIT_MSB         43
`define SSQ_MON_TGT_LSB          44
`define SSQ_MON_TGT_MSB          49
`define SSQ_TIME_TGT_LSB         50
`define SSQ_TIME_TGT_MSB         55
`define SSQ_ADV_TGT_LSB          56
`define SSQ_ADV_TGT_MSB          61
`define SSQ_ROUND_ROBIN_BIT      62
`define SSQ_FAULT_LATCH_BIT      63
`define SSQ_ROT_CTRL_RR_BIT      2

`define SSQ_RESET_STATE          6'h00
`define SSQ_WORD_RESET           64'h0000_0000_0000_0000

`define SSQ_TICK_NS              100000
`define SSQ_CLK_PERIOD_NS        10
`define SSQ_TICK_CYCLES          (`SSQ_TICK_NS / `SSQ_CLK_PERIOD_NS)

`endif

// ---- hdl/ssq_pkg.sv ----
// Types shared by the supply sequencer files
package ssq_pkg;

    typedef enum logic [3:0] {
        SSQ_SEL_NEVER   = 4'h0,
        SSQ_SEL_NA1     = 4'h1,
        SSQ_SEL_POS_ONE = 4'h2,
        SSQ_SEL_POS_TWO = 4'h3,
        SSQ_SEL_POS_THR = 4'h4,
        SSQ_SEL_HIGH_V  = 4'h5,
        SSQ_SEL_NA6     = 4'h6,
        SSQ_SEL_AUX_ONE = 4'h7,
        SSQ_SEL_AUX_TWO = 4'h8,
        SSQ_SEL_AUX_THR = 4'h9,
        SSQ_SEL_AUX_FOU = 4'ha,
        SSQ_SEL_WARNING = 4'hb,
        SSQ_SEL_HOST    = 4'hc
    } ssq_select_e;

    typedef enum logic [1:0] {
        SSQ_PH_ENTER = 2'b01,
        SSQ_PH_RUN   = 2'b10
    } ssq_phase_e;

    typedef struct packed {
        logic        fault_latch_open;
        logic        round_robin;
        logic [5:0]  advance_target;
        logic [5:0]  time_limit_target;
        logic [5:0]  monitor_fault_target;
        logic [3:0]  advance_wait_code;
        logic        advance_polarity;
        logic [3:0]  advance_input_select;
        logic [3:0]  time_limit_code;
    } ssq_state_cfg_s;

    typedef struct packed {
        logic positive_supply_in_one;
        logic positive_supply_in_two;
        logic positive_supply_in_three;
        logic high_voltage_input;
        logic aux_input_one;
        logic aux_input_two;
        logic aux_input_three;
        logic aux_input_four;
        logic warning;
    } ssq_monitor_s;

endpackage

// ---- hdl/ssq_delay_decode.sv ----
// Decodes a 4-bit delay or time limit code into 0.1 ms ticks
`timescale 1ns/1ps
module ssq_delay_decode (
    input  wire logic [3:0]  code_in,   // Delay code
    output logic      [11:0] ticks_out  // Length in 0.1 ms ticks
);

    always_comb begin
        case (code_in)
            4'h1:    ticks_out = 12'h001;
            4'h2:    ticks_out = 12'h002;
            4'h3:    ticks_out = 12'h004;
            4'h4:    ticks_out = 12'h007;
            4'h5:    ticks_out = 12'h00a;
            4'h6:    ticks_out = 12'h014;
            4'h7:    ticks_out = 12'h028;
            4'h8:    ticks_out = 12'h046;
            4'h9:    ticks_out = 12'h064;
            4'ha:    ticks_out = 12'h0c8;
            4'hb:    ticks_out = 12'h190;
            4'hc:    ticks_out = 12'h2bc;
            4'hd:    ticks_out = 12'h3e8;
            4'he:    ticks_out = 12'h7d0;
            4'hf:    ticks_out = 12'hfa0;
            // Unusable code: treated as the shortest length
            default: ticks_out = 12'h001;
        endcase
    end

endmodule

// ---- hdl/ssq_state_engine.sv ----
// Supply sequencer state transition engine with per-state words
`timescale 1ns/1ps
`include "ssq_regs.svh"

// Summary of operation
// - Bits 40-43 hold advance wait code
// - Monitor fault jumps to target in 44-49
// - Time limit expiry jumps to 50-55 target
// - Met advance condition moves to 56-61
// - Round robin is bit 62 OR control bit 2
// - Bit 63 opens the fault latch
// - Codes 1-15 map 0.1 to 400 ms
// - Select picks supply, aux or warning input
// - Select 12 waits for host jump command
// - Bits 31-34 hold time limit code
// - Bits 35-38 hold advance input select
module ssq_state_engine #(
    parameter int TICK_CYCLES = `SSQ_TICK_CYCLES, // Cycles per 0.1 ms
    parameter int STATES      = 64               // Number of state words
) (
    input  wire logic                 sys_clk_in,      // 100 MHz clock
    input  wire logic                 nrst_in,         // Async reset, low
    input  wire ssq_pkg::ssq_monitor_s monitor_in,     // Comparator levels
    input  wire logic                 monitor_fault_in, // Unmasked fault
    input  wire logic                 host_jump_in,    // Host jump pulse
    input  wire logic [7:0]           rotation_control_reg_in, // Rotation
    input  wire logic                 cfg_we_in,       // Word byte write
    input  wire logic [5:0]           cfg_state_in,    // State addressed
    input  wire logic [2:0]           cfg_reg_in,      // Byte of the word
    input  wire logic [7:0]           cfg_wdata_in,    // Write data
    output logic      [7:0]           cfg_rdata_out,   // Read data
    output logic      [5:0]           current_state_out, // Active state
    output logic                      round_robin_en_out, // Effective RR
    output logic                      fault_latch_open_out, // Latch open
    output logic                      monitor_jump_out, // Fault jump pulse
    output logic                      timeout_jump_out, // Timeout pulse
    output logic                      advance_jump_out, // Advance pulse
    output logic                      host_jump_pending_out // Host pending
);

    logic [63:0] word_mem [STATES];
    logic [63:0] word_cur;
    ssq_pkg::ssq_state_cfg_s cfg;

    // Word storage, one byte lane per written register
    always_ff @(posedge sys_clk_in) begin
        if (cfg_we_in) begin
            word_mem[cfg_state_in][{cfg_reg_in, 3'h0} +: 8] <= cfg_wdata_in;
        end
    end

    assign word_cur = word_mem[current_state_out];

    always_comb begin
        cfg.time_limit_code      =
            word_cur[`SSQ_TIMEOUT_MSB:`SSQ_TIMEOUT_LSB];
        cfg.advance_input_select =
            word_cur[`SSQ_SELECT_MSB:`SSQ_SELECT_LSB];
        cfg.advance_polarity     = word_cur[`SSQ_POLARITY_BIT];
        cfg.advance_wait_code    =
            word_cur[`SSQ_ADV_WAIT_MSB:`SSQ_ADV_WAIT_LSB];
        cfg.monitor_fault_target =
            word_cur[`SSQ_MON_TGT_MSB:`SSQ_MON_TGT_LSB];
        cfg.time_limit_target    =
            word_cur[`SSQ_TIME_TGT_MSB:`SSQ_TIME_TGT_LSB];
        cfg.advance_target       =
            word_cur[`SSQ_ADV_TGT_MSB:`SSQ_ADV_TGT_LSB];
        cfg.round_robin          = word_cur[`SSQ_ROUND_ROBIN_BIT];
        cfg.fault_latch_open     = word_cur[`SSQ_FAULT_LATCH_BIT];
    end

    logic [11:0] wait_ticks;
    logic [11:0] limit_ticks;

    ssq_delay_decode u_wait_decode (
        .code_in   (cfg.advance_wait_code),
        .ticks_out (wait_ticks)
    );

    ssq_delay_decode u_limit_decode (
        .code_in   (cfg.time_limit_code),
        .ticks_out (limit_ticks)
    );

    // Selected advance source
    logic sel_level;
    logic adv_cond;

    always_comb begin
        case (ssq_pkg::ssq_select_e'(cfg.advance_input_select))
            ssq_pkg::SSQ_SEL_POS_ONE: sel_level =
                monitor_in.positive_supply_in_one;
            ssq_pkg::SSQ_SEL_POS_TWO: sel_level =
                monitor_in.positive_supply_in_two;
            ssq_pkg::SSQ_SEL_POS_THR: sel_level =
                monitor_in.positive_supply_in_three;
            ssq_pkg::SSQ_SEL_HIGH_V:  sel_level =
                monitor_in.high_voltage_input;
            ssq_pkg::SSQ_SEL_AUX_ONE: sel_level = monitor_in.aux_input_one;
            ssq_pkg::SSQ_SEL_AUX_TWO: sel_level = monitor_in.aux_input_two;
            ssq_pkg::SSQ_SEL_AUX_THR: sel_level = monitor_in.aux_input_three;
            ssq_pkg::SSQ_SEL_AUX_FOU: sel_level = monitor_in.aux_input_four;
            ssq_pkg::SSQ_SEL_WARNING: sel_level = monitor_in.warning;
            ssq_pkg::SSQ_SEL_HOST:    sel_level =
                host_jump_pending_out;
            // Select 0 and the inapplicable codes stay low
            default:                  sel_level = 1'b0;
        endcase
        // Polarity 0 advances on high, 1 on low
        adv_cond = sel_level ^ cfg.advance_polarity;
    end

    // Time base and transition state
    ssq_pkg::ssq_phase_e phase_reg, phase_next;
    logic [31:0] pre_reg, pre_next;
    logic [11:0] ticks_reg, ticks_next;
    logic [5:0]  state_next;
    logic        mon_next, tmo_next, adv_next, host_next;
    logic        rr_next, latch_next;
    logic [7:0]  rdata_next;
    logic        tick;

    always_comb begin
        phase_next = phase_reg;
        pre_next   = pre_reg;
        ticks_next = ticks_reg;
        state_next = current_state_out;
        mon_next   = 1'b0;
        tmo_next   = 1'b0;
        adv_next   = 1'b0;
        tick       = (pre_reg == 32'(TICK_CYCLES - 1));
        case (phase_reg)
            ssq_pkg::SSQ_PH_ENTER: begin
                // Time base restarts on each entry
                pre_next   = 32'h0;
                ticks_next = 12'h000;
                phase_next = ssq_pkg::SSQ_PH_RUN;
            end
            ssq_pkg::SSQ_PH_RUN: begin
                pre_next = tick ? 32'h0 : pre_reg + 32'h1;
                if (tick && ticks_reg != 12'hfff) begin
                    ticks_next = ticks_reg + 12'h001;
                end
                if (monitor_fault_in) begin
                    state_next = cfg.monitor_fault_target;
                    mon_next   = 1'b1;
                    phase_next = ssq_pkg::SSQ_PH_ENTER;
                end else if (ticks_reg >= limit_ticks) begin
                    state_next = cfg.time_limit_target;
                    tmo_next   = 1'b1;
                    phase_next = ssq_pkg::SSQ_PH_ENTER;
                end else if (adv_cond && ticks_reg >= wait_ticks) begin
                    state_next = cfg.advance_target;
                    adv_next   = 1'b1;
                    phase_next = ssq_pkg::SSQ_PH_ENTER;
                end
            end
            default: begin
                phase_next = ssq_pkg::SSQ_PH_ENTER;
            end
        endcase
        // Host request self-clears on any jump, even to the same state; a new one wins
        host_next = host_jump_in ||
                    (host_jump_pending_out &&
                     phase_next != ssq_pkg::SSQ_PH_ENTER);
        rr_next    = cfg.round_robin |
                     rotation_control_reg_in[`SSQ_ROT_CTRL_RR_BIT];
        latch_next = cfg.fault_latch_open;
        rdata_next = word_mem[cfg_state_in][{cfg_reg_in, 3'h0} +: 8];
    end

    always_ff @(posedge sys_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            phase_reg             <= ssq_pkg::SSQ_PH_ENTER;
            pre_reg               <= 32'h0;
            ticks_reg             <= 12'h000;
            current_state_out     <= `SSQ_RESET_STATE;
            monitor_jump_out      <= 1'b0;
            timeout_jump_out      <= 1'b0;
            advance_jump_out      <= 1'b0;
            host_jump_pending_out <= 1'b0;
            round_robin_en_out    <= 1'b0;
            fault_latch_open_out  <= 1'b0;
            cfg_rdata_out         <= 8'h00;
        end else begin
            phase_reg             <= phase_next;
            pre_reg               <= pre_next;
            ticks_reg             <= ticks_next;
            current_state_out     <= state_next;
            monitor_jump_out      <= mon_next;
            timeout_jump_out      <= tmo_next;
            advance_jump_out      <= adv_next;
            host_jump_pending_out <= host_next;
            round_robin_en_out    <= rr_next;
            fault_latch_open_out  <= latch_next;
            cfg_rdata_out         <= rdata_next;
        end
    end

endmodule

// ---- sim/ssq_state_engine_props.sv ----
// Port relation checker of the sequencer engine
`timescale 1ns/1ps
module ssq_state_engine_props #(
    parameter int TICK_CYCLES = 4  // Cycles per tick
) (
    input  wire logic       sys_clk_in,            // Clock
    input  wire logic       nrst_in,               // Reset, low
    input  wire logic       monitor_fault_in,      // Fault level
    input  wire logic       host_jump_in,          // Host pulse
    input  wire logic [5:0] current_state_out,     // Active state
    input  wire logic       monitor_jump_out,      // Fault jump
    input  wire logic       timeout_jump_out,      // Timeout jump
    input  wire logic       advance_jump_out,      // Advance jump
    input  wire logic       host_jump_pending_out  // Host pending
);
    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (!nrst_in);
    logic        any_jump;
    int unsigned gap_reg;
    int unsigned gap_next;
    assign any_jump = monitor_jump_out | timeout_jump_out | advance_jump_out;
    always_comb begin
        gap_next = any_jump ? 0 : gap_reg + ((gap_reg < 9999) ? 1 : 0);
    end
    always_ff @(posedge sys_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            gap_reg <= 0;
        end else begin
            gap_reg <= gap_next;
        end
    end
    chk_one_kind: assert property ($onehot0({monitor_jump_out,
        timeout_jump_out, advance_jump_out})) else $error("two jumps");
    chk_mon_cause: assert property (monitor_jump_out |->
        $past(monitor_fault_in)) else $error("jump without fault");
    chk_mon_first: assert property (timeout_jump_out ||
        advance_jump_out |-> !$past(monitor_fault_in)) else $error("prio");
    chk_hold_state: assert property (!any_jump |->
        $stable(current_state_out)) else $error("state moved");
    chk_enter_gap: assert property (any_jump |=> !any_jump)
        else $error("jumps too close");
    chk_host_set: assert property (host_jump_in |=>
        host_jump_pending_out) else $error("host not pending");
    chk_host_clear: assert property (any_jump && !host_jump_in &&
        !$past(host_jump_in) |=> !host_jump_pending_out)
        else $error("pending kept");
    chk_timeout_min: assert property (timeout_jump_out |->
        gap_reg >= TICK_CYCLES) else $error("timeout too early");
    cov_mon: cover property (monitor_jump_out);
    cov_tmo: cover property (timeout_jump_out);
    cov_host: cover property (host_jump_pending_out ##1 advance_jump_out);
endmodule
bind ssq_state_engine ssq_state_engine_props #(
    .TICK_CYCLES(TICK_CYCLES)) i_ssq_state_engine_props (.sys_clk_in,
    .nrst_in, .monitor_fault_in, .host_jump_in, .current_state_out,
    .monitor_jump_out, .timeout_jump_out, .advance_jump_out,
    .host_jump_pending_out);

// ---- sim/ssq_supply_model.sv ----
// Comparator levels and host command source
`timescale 1ns/1ps
module ssq_supply_model (
    input  wire logic             sys_clk_in,   // Clock
    input  wire logic [8:0]       level_in,     // Wanted levels
    input  wire logic             host_req_in,  // Host request
    output ssq_pkg::ssq_monitor_s monitor_out,  // Comparator levels
    output logic                  host_jump_out // Host command pulse
);
    logic seen;
    always_ff @(posedge sys_clk_in) begin
        monitor_out   <= ssq_pkg::ssq_monitor_s'(level_in);
        host_jump_out <= host_req_in & ~seen;
        seen          <= host_req_in;
    end
endmodule

// ---- sim/test_ssq_state_engine.sv ----
// Self-checking bench of the sequencer engine
`timescale 1ns/1ps
module test_ssq_state_engine;
    localparam int TC = 4;
    localparam int DEC[16] = '{1, 1, 2, 4, 7, 10, 20, 40, 70, 100, 200, 400,
                               700, 1000, 2000, 4000};
    typedef struct packed {
        logic [15:0] sel_pol_wt_tmo;
        logic [3:0]  mf;
        logic [11:0] lvl;
        logic [3:0]  host;
        logic [3:0]  kind;
    } ssq_row_s;
    // Select, polarity, wait, timeout, fault, levels, host, jump kind
    ssq_row_s rows[18] = '{40'h2013_0100_03, 40'h3013_0080_03,
        40'h4013_0040_03, 40'h5013_0020_03, 40'h7013_0010_03,
        40'h8013_0008_03, 40'h9013_0004_03, 40'ha013_0002_03,
        40'hb013_0001_03, 40'h0013_01ff_02, 40'h1013_01ff_02,
        40'h6011_01ff_02, 40'hc013_0000_13, 40'hc014_01ff_02,
        40'h2013_1100_01, 40'h2113_00ff_03, 40'h2043_0100_02,
        40'h2023_0100_03};
    logic                  sys_clk_in = 1'b0;
    logic                  nrst_in, mf, we, hreq, rr, fl, mj, tj, aj, hp, hj;
    logic [8:0]            lvl;
    logic [7:0]            rot, wd, rdata;
    logic [5:0]            cst, cur;
    logic [2:0]            creg;
    ssq_pkg::ssq_monitor_s mon;
    int                    err_total, total_checks;
    always #5 sys_clk_in = ~sys_clk_in;
    ssq_supply_model i_ssq_supply_model (.sys_clk_in, .level_in(lvl),
        .host_req_in(hreq), .monitor_out(mon), .host_jump_out(hj));
    ssq_state_engine #(.TICK_CYCLES(TC)) i_ssq_state_engine (.sys_clk_in,
        .nrst_in, .monitor_in(mon), .monitor_fault_in(mf), .host_jump_in(hj),
        .rotation_control_reg_in(rot), .cfg_we_in(we), .cfg_state_in(cst),
        .cfg_reg_in(creg), .cfg_wdata_in(wd), .cfg_rdata_out(rdata),
        .current_state_out(cur), .round_robin_en_out(rr),
        .fault_latch_open_out(fl), .monitor_jump_out(mj),
        .timeout_jump_out(tj), .advance_jump_out(aj),
        .host_jump_pending_out(hp));
    function automatic ssq_pkg::ssq_state_cfg_s mk(input logic [15:0] c,
                                                    input logic rr_v);
        mk = '{~rr_v, rr_v, 6'h33, 6'h22, 6'h11, c[7:4], c[8], c[15:12],
               c[3:0]};
    endfunction
    task automatic tally_and_finish;
        if (err_total == 0 && total_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic chk_val(input logic [7:0] g, input logic [7:0] e);
        total_checks++;
        if (g !== e) begin
            err_total++;
            $display("wrong value at %0t: %h, expected %h", $time, g, e);
        end
    endtask
    task automatic chk_bit(input logic g, input logic e);
        chk_val({7'h0, g}, {7'h0, e});
    endtask
    task automatic wr_word(input logic [5:0] s, input logic [63:31] w);
        for (int b = 3; b < 8; b++) begin
            @(posedge sys_clk_in);
            we   <= 1'b1;
            cst  <= s;
            creg <= b[2:0];
            wd   <= 8'({w, 31'h0} >> (8 * b));
        end
        @(posedge sys_clk_in);
        we <= 1'b0;
    endtask
    task automatic run_row(input ssq_row_s r);
        int   n;
        logic hp_seen;
        @(posedge sys_clk_in);
        nrst_in <= 1'b0;
        hreq    <= 1'b0;
        mf      <= 1'b0;
        lvl     <= r.lvl[8:0];
        wr_word(6'h00, mk(r.sel_pol_wt_tmo, 1'b0));
        nrst_in <= 1'b1;
        mf      <= r.mf[0];
        hreq    <= r.host[0];
        n = 0;
        hp_seen = 1'b0;
        do begin
            @(negedge sys_clk_in);
            n++;
            hp_seen = hp_seen | hp;
        end while ((mj | tj | aj) !== 1'b1 && n < 300);
        if (n >= 300) begin
            err_total++;
            tally_and_finish();
        end
        chk_val({6'h0, tj | aj, mj | aj}, {4'h0, r.kind});
        chk_val({2'h0, cur}, {4'h0, r.kind} * 8'h11);
        chk_bit(hp_seen, r.host[0]);
        chk_bit(hp, 1'b0);
        if (r.kind == 4'h2) begin
            n = n - DEC[r.sel_pol_wt_tmo[3:0]] * TC;
            chk_bit(n >= 0 && n <= TC + 4, 1'b1);
        end
    endtask
    initial begin
        logic [63:0] w;
        {nrst_in, mf, we, hreq, lvl, rot, wd, cst, creg} = '0;
        repeat (10) @(posedge sys_clk_in);
        for (int t = 1; t < 4; t++) wr_word(6'(t * 17), mk(16'h001f, 1'b1));
        foreach (rows[i]) run_row(rows[i]);
        repeat (2) @(negedge sys_clk_in);
        chk_bit(rr, 1'b1);
        chk_bit(fl, 1'b0);
        @(posedge sys_clk_in);
        nrst_in <= 1'b0;
        rot     <= 8'hfb;
        w = {mk(16'h001f, 1'b0), 31'h0};
        wr_word(6'h00, w[63:31]);
        nrst_in <= 1'b1;
        repeat (3) @(negedge sys_clk_in);
        chk_bit(rr, 1'b0);
        chk_bit(fl, 1'b1);
        @(posedge sys_clk_in);
        rot <= 8'h04;
        repeat (2) @(negedge sys_clk_in);
        chk_bit(rr, 1'b1);
        for (int b = 3; b < 8; b++) begin
            @(posedge sys_clk_in);
            creg <= b[2:0];
            @(negedge sys_clk_in);
            @(negedge sys_clk_in);
            chk_val(rdata, w[8 * b +: 8]);
        end
        tally_and_finish();
    end
endmodule
